/* src/teie_exec.sv */
// Decoder and executor for the thread and VIRTUAL_PROCESSOR_ELEMENT enable and disable instructions.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Without multithreading present, every group instruction with system coprocessor access raises Reserved Instruction.
// - These instructions run only where system coprocessor access is allowed.
// - Coprocessor Unusable for unit 0 takes precedence over Reserved Instruction.
// - Disable threads returns the per-VIRTUAL_PROCESSOR_ELEMENT control register, then clears threads_on.
// - Clearing threads_on leaves every thread context halted state untouched.
// - Thread pair always uses coprocessor register 1 select 1.
// - VIRTUAL_PROCESSOR_ELEMENT pair always uses coprocessor register 0 select 1.
// - Set-clear bit 0 clears, 1 sets, after the old value returns.
// - Thread pair writes the set-clear bit straight into threads_on.
// - Disable VPEs returns the processor-wide register, then clears vpes_enabled.
// - Without master flag, VIRTUAL_PROCESSOR_ELEMENT pair returns the value but keeps vpes_enabled.
// - Read and bit update happen as one indivisible step.
// - With no target named, register zero is the destination and discards.
// - Setting vpes_enabled lets every non-inhibited VIRTUAL_PROCESSOR_ELEMENT run concurrently.
module teie_exec (
	input  wire logic                         mclk_in,
	input  wire logic                         rst_in,
	// Instruction issue from the pipeline.
	input  wire logic                         instr_valid_in,
	input  wire logic [31:0]                  instr_word_in,
	input  wire logic                         cop_access_in,
	input  wire logic                         multithread_present_in,
	input  wire logic                         master_flag_in,
	input  wire logic [teie_pkg::NUM_VPE-1:0] vpe_inhibit_in,
	// Result towards the pipeline.
	output logic                              instr_claimed_out,
	output logic                              exc_cop_unusable_out,
	output logic [1:0]                        exc_cop_unit_out,
	output logic                              exc_reserved_out,
	output logic                              gpr_wr_out,
	output logic [4:0]                        gpr_idx_out,
	output logic [31:0]                       gpr_data_out,
	output logic [4:0]                        cop_rd_out,
	output logic [2:0]                        cop_sel_out,
	// Execution control.
	output logic                              threads_on_out,
	output logic                              vpes_enabled_out,
	output logic [teie_pkg::NUM_VPE-1:0]      vpe_run_out,
	// Register port.
	input  wire logic [7:0]                   reg_addr_in,
	input  wire logic [31:0]                  reg_wdata_in,
	input  wire logic                         reg_wr_in,
	input  wire logic                         reg_rd_in,
	output logic [31:0]                       reg_rdata_out,
	output logic                              irq_out
);

	// ************************************************************
	// Decode.
	// ************************************************************

	logic               is_group;
	logic               is_thread;
	logic               set_clear_bit;
	logic [4:0]         target_gpr;
	teie_pkg::teie_chk_t chk;

	// Fixed fields of the group; the select field picks the target pair.
	always_comb begin
		is_group = instr_valid_in
			&& instr_word_in[teie_pkg::OPC_HI:teie_pkg::OPC_LO] == teie_pkg::OPC_VALUE
			&& instr_word_in[teie_pkg::MID_HI:teie_pkg::MID_LO] == teie_pkg::MID_VALUE
			&& instr_word_in[teie_pkg::FN_HI:teie_pkg::FN_LO] == teie_pkg::FN_VALUE
			&& instr_word_in[teie_pkg::LOW_HI:0] == teie_pkg::LOW_VALUE
			&& (instr_word_in[teie_pkg::SEL_HI:teie_pkg::SEL_LO] == teie_pkg::SEL_THREAD
			|| instr_word_in[teie_pkg::SEL_HI:teie_pkg::SEL_LO] == teie_pkg::SEL_VPE);
		is_thread  = instr_word_in[teie_pkg::SEL_HI:teie_pkg::SEL_LO] == teie_pkg::SEL_THREAD;
		set_clear_bit = instr_word_in[teie_pkg::SET_CLEAR_POS];
		// An omitted target assembles as register zero, which the core discards.
		target_gpr = instr_word_in[teie_pkg::TGT_HI:teie_pkg::TGT_LO];
	end

	// Privilege is checked before feature presence.
	always_comb begin
		if (!is_group) begin
			chk = teie_pkg::TEIE_CHK_NONE;
		end else if (!cop_access_in) begin
			chk = teie_pkg::TEIE_CHK_COP_UNUSABLE;
		end else if (!multithread_present_in) begin
			chk = teie_pkg::TEIE_CHK_RESERVED;
		end else begin
			chk = teie_pkg::TEIE_CHK_EXECUTE;
		end
	end

	// ************************************************************
	// Control registers.
	// ************************************************************

	logic [31:0] per_vpe_ctrl_ff;
	logic [31:0] multi_processor_ctrl_ff;
	logic [31:0] nxt_per_vpe_ctrl;
	logic [31:0] nxt_multi_processor_ctrl;
	logic        exec_thread;
	logic        exec_vpe;
	logic        vpe_update;
	logic        bus_wr_pvc;
	logic        bus_wr_mpc;

	assign exec_thread = chk == teie_pkg::TEIE_CHK_EXECUTE && is_thread;
	assign exec_vpe    = chk == teie_pkg::TEIE_CHK_EXECUTE && !is_thread;
	assign vpe_update  = exec_vpe && master_flag_in;
	assign bus_wr_pvc  = reg_wr_in && reg_addr_in == teie_pkg::OFS_PER_VPE_CTRL;
	assign bus_wr_mpc  = reg_wr_in && reg_addr_in == teie_pkg::OFS_MULTI_CTRL;

	// Per-VIRTUAL_PROCESSOR_ELEMENT register: the instruction owns it in its cycle, so a port write
	// landing in the same cycle is dropped instead of splitting the update.
	always_comb begin
		nxt_per_vpe_ctrl = per_vpe_ctrl_ff;
		if (exec_thread) begin
			// Only threads_on moves; the old word was already sampled for return.
			nxt_per_vpe_ctrl[teie_pkg::THREADS_ON_POS] =
				set_clear_bit;
		end else if (bus_wr_pvc) begin
			nxt_per_vpe_ctrl = reg_wdata_in;
		end
	end

	// Processor-wide register, same ownership as above.
	always_comb begin
		nxt_multi_processor_ctrl = multi_processor_ctrl_ff;
		if (exec_vpe) begin
			if (vpe_update) begin
				nxt_multi_processor_ctrl[teie_pkg::VPES_ENABLED_POS] =
					set_clear_bit;
			end
		end else if (bus_wr_mpc) begin
			nxt_multi_processor_ctrl = reg_wdata_in;
		end
	end

	// Per-VIRTUAL_PROCESSOR_ELEMENT control state; halted state of thread contexts lives elsewhere
	// and is never written here.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			per_vpe_ctrl_ff <= teie_pkg::PVC_RESET;
		end else begin
			per_vpe_ctrl_ff <= nxt_per_vpe_ctrl;
		end
	end

	// Processor-wide control state.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			multi_processor_ctrl_ff <= teie_pkg::MPC_RESET;
		end else begin
			multi_processor_ctrl_ff <= nxt_multi_processor_ctrl;
		end
	end

	// Enable levels toward the thread scheduler.
	always_comb begin
		threads_on_out   = per_vpe_ctrl_ff[teie_pkg::THREADS_ON_POS];
		vpes_enabled_out = multi_processor_ctrl_ff[teie_pkg::VPES_ENABLED_POS];
		// Every VIRTUAL_PROCESSOR_ELEMENT that is not inhibited may run while vpes_enabled is set.
		vpe_run_out = vpes_enabled_out ? ~vpe_inhibit_in : '0;
	end

	// ************************************************************
	// Result toward the pipeline.
	// ************************************************************

	logic        claimed_ff;
	logic        cop_unusable_ff;
	logic        reserved_ff;
	logic        gpr_wr_ff;
	logic [4:0]  gpr_idx_ff;
	logic [31:0] gpr_data_ff;
	logic [4:0]  cop_rd_ff;
	logic [2:0]  cop_sel_ff;
	logic [31:0] last_result_ff;

	// Exception and claim pulses, one cycle after issue.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			claimed_ff      <= 1'b0;
			cop_unusable_ff <= 1'b0;
			reserved_ff     <= 1'b0;
		end else begin
			claimed_ff      <= chk != teie_pkg::TEIE_CHK_NONE;
			cop_unusable_ff <= chk == teie_pkg::TEIE_CHK_COP_UNUSABLE;
			reserved_ff     <= chk == teie_pkg::TEIE_CHK_RESERVED;
		end
	end

	// General register write-back carries the value from before the update.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			gpr_wr_ff   <= 1'b0;
			gpr_idx_ff  <= 5'h00;
			gpr_data_ff <= 32'h0000_0000;
			cop_rd_ff   <= 5'h00;
			cop_sel_ff  <= 3'h0;
		end else begin
			gpr_wr_ff <= chk == teie_pkg::TEIE_CHK_EXECUTE;
			if (chk == teie_pkg::TEIE_CHK_EXECUTE) begin
				gpr_idx_ff <= target_gpr;
				if (is_thread) begin
					gpr_data_ff <= per_vpe_ctrl_ff;
					cop_rd_ff   <= teie_pkg::PVC_RD;
					cop_sel_ff  <= teie_pkg::PVC_SEL;
				end else begin
					gpr_data_ff <= multi_processor_ctrl_ff;
					cop_rd_ff   <= teie_pkg::MPC_RD;
					cop_sel_ff  <= teie_pkg::MPC_SEL;
				end
			end
		end
	end

	// Copy of the last returned word for software to inspect.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			last_result_ff <= 32'h0000_0000;
		end else if (chk == teie_pkg::TEIE_CHK_EXECUTE) begin
			last_result_ff <= is_thread ? per_vpe_ctrl_ff : multi_processor_ctrl_ff;
		end
	end

	// Result ports come straight from their flip-flops; the exception unit number is tied to 0.
	assign instr_claimed_out    = claimed_ff;
	assign exc_cop_unusable_out = cop_unusable_ff;
	assign exc_cop_unit_out     = 2'h0;
	assign exc_reserved_out     = reserved_ff;
	assign gpr_wr_out           = gpr_wr_ff;
	assign gpr_idx_out          = gpr_idx_ff;
	assign gpr_data_out         = gpr_data_ff;
	assign cop_rd_out           = cop_rd_ff;
	assign cop_sel_out          = cop_sel_ff;

	// ************************************************************
	// Events and interrupt.
	// ************************************************************

	logic [teie_pkg::EVT_WIDTH-1:0] evt;
	logic [teie_pkg::EVT_WIDTH-1:0] evt_status;
	logic [teie_pkg::EVT_WIDTH-1:0] evt_mask;

	// One event per outcome of an issued group instruction.
	always_comb begin
		evt = teie_pkg::EVT_RESET;
		evt[teie_pkg::EVT_THREAD_OP] = exec_thread;
		evt[teie_pkg::EVT_VPE_OP]    = exec_vpe;
		evt[teie_pkg::EVT_COP_UNUSE] = chk == teie_pkg::TEIE_CHK_COP_UNUSABLE;
		evt[teie_pkg::EVT_RESERVED]  = chk == teie_pkg::TEIE_CHK_RESERVED;
		evt[teie_pkg::EVT_NOT_MASTR] = exec_vpe && !master_flag_in;
	end

	// Sticky status with write-one-to-clear and mask.
	teie_evt_bank #(
		.WIDTH (teie_pkg::EVT_WIDTH)
	) u_evt_bank (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.event_in     (evt),
		.clr_wr_in    (reg_wr_in && reg_addr_in == teie_pkg::OFS_IRQ_STATUS),
		.clr_data_in  (reg_wdata_in[teie_pkg::EVT_WIDTH-1:0]),
		.mask_wr_in   (reg_wr_in && reg_addr_in == teie_pkg::OFS_IRQ_MASK),
		.mask_data_in (reg_wdata_in[teie_pkg::EVT_WIDTH-1:0]),
		.status_out   (evt_status),
		.mask_out     (evt_mask),
		.irq_out      (irq_out)
	);

	// ************************************************************
	// Register read port.
	// ************************************************************

	logic [31:0] rdata_ff;

	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				teie_pkg::OFS_PER_VPE_CTRL: rdata_ff <= per_vpe_ctrl_ff;
				teie_pkg::OFS_MULTI_CTRL:   rdata_ff <= multi_processor_ctrl_ff;
				teie_pkg::OFS_IRQ_STATUS: begin
					rdata_ff <= {{(32-teie_pkg::EVT_WIDTH){1'b0}}, evt_status};
				end
				teie_pkg::OFS_IRQ_MASK: begin
					rdata_ff <= {{(32-teie_pkg::EVT_WIDTH){1'b0}}, evt_mask};
				end
				teie_pkg::OFS_LAST_RESULT:  rdata_ff <= last_result_ff;
				default:                    rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign reg_rdata_out = rdata_ff;

endmodule : teie_exec

`default_nettype wire

/* src/teie_pkg.sv */
// Constants and types shared by the thread and VIRTUAL_PROCESSOR_ELEMENT enable instruction executor.
package teie_pkg;

	// ************************************************************
	// Instruction word fields.
	// ************************************************************
	localparam int          OPC_HI        = 31;
	localparam int          OPC_LO        = 26;
	localparam logic [5:0]  OPC_VALUE     = 6'h08;
	localparam int          TGT_HI        = 25;
	localparam int          TGT_LO        = 21;
	localparam int          SEL_HI        = 20;
	localparam int          SEL_LO        = 16;
	localparam logic [4:0]  SEL_THREAD    = 5'h01;
	localparam logic [4:0]  SEL_VPE       = 5'h00;
	localparam int          MID_HI        = 15;
	localparam int          MID_LO        = 11;
	localparam logic [4:0]  MID_VALUE     = 5'h01;
	localparam int          SET_CLEAR_POS = 10;
	localparam int          FN_HI         = 9;
	localparam int          FN_LO         = 3;
	localparam logic [6:0]  FN_VALUE      = 7'h56;
	localparam int          LOW_HI        = 2;
	localparam logic [2:0]  LOW_VALUE     = 3'h0;

	// ************************************************************
	// Hard-coded system coprocessor register numbers.
	// ************************************************************
	localparam logic [4:0]  PVC_RD        = 5'h01;
	localparam logic [2:0]  PVC_SEL       = 3'h1;
	localparam logic [4:0]  MPC_RD        = 5'h00;
	localparam logic [2:0]  MPC_SEL       = 3'h1;

	// ************************************************************
	// Control register layout and reset values.
	// ************************************************************
	localparam int          THREADS_ON_POS   = 15;
	localparam int          VPES_ENABLED_POS = 0;
	localparam logic [31:0] PVC_RESET        = 32'h0000_0000;
	localparam logic [31:0] MPC_RESET        = 32'h0000_0000;
	localparam int          NUM_VPE          = 2;

	// ************************************************************
	// Register port offsets.
	// ************************************************************
	localparam logic [7:0]  OFS_PER_VPE_CTRL = 8'h00;
	localparam logic [7:0]  OFS_MULTI_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK     = 8'h0C;
	localparam logic [7:0]  OFS_LAST_RESULT  = 8'h10;

	// ************************************************************
	// Interrupt event bits.
	// ************************************************************
	localparam int          EVT_WIDTH     = 5;
	localparam int          EVT_THREAD_OP = 0;
	localparam int          EVT_VPE_OP    = 1;
	localparam int          EVT_COP_UNUSE = 2;
	localparam int          EVT_RESERVED  = 3;
	localparam int          EVT_NOT_MASTR = 4;
	localparam logic [4:0]  EVT_RESET     = 5'h00;

	// Outcome of checking one instruction of the group.
	typedef enum logic [1:0] {
		TEIE_CHK_NONE,
		TEIE_CHK_COP_UNUSABLE,
		TEIE_CHK_RESERVED,
		TEIE_CHK_EXECUTE
	} teie_chk_t;

endpackage : teie_pkg

/* src/teie_evt_bank.sv */
// Sticky event status bits with write-one-to-clear, mask and level interrupt.
`timescale 1ns/1ns
`default_nettype none

module teie_evt_bank #(
	parameter int WIDTH = 5
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] event_in,
	input  wire logic             clr_wr_in,
	input  wire logic [WIDTH-1:0] clr_data_in,
	input  wire logic             mask_wr_in,
	input  wire logic [WIDTH-1:0] mask_data_in,
	output logic      [WIDTH-1:0] status_out,
	output logic      [WIDTH-1:0] mask_out,
	output logic                  irq_out
);

	logic [WIDTH-1:0] status_ff;
	logic [WIDTH-1:0] mask_ff;
	logic [WIDTH-1:0] nxt_status;

	// A new event wins over a clear written in the same cycle.
	always_comb begin
		nxt_status = status_ff;
		if (clr_wr_in) begin
			nxt_status = nxt_status & ~clr_data_in;
		end
		nxt_status = nxt_status | event_in;
	end

	// Status bits hold until software writes a one to them.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Mask bits enable the matching status bits onto the interrupt.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mask_ff <= '0;
		end else if (mask_wr_in) begin
			mask_ff <= mask_data_in;
		end
	end

	// Interrupt level and register views.
	assign status_out = status_ff;
	assign mask_out   = mask_ff;
	assign irq_out    = |(status_ff & mask_ff);

endmodule : teie_evt_bank

`default_nettype wire

/* verif/teie_exec_asserts.sv */
// Concurrent checks on the ports of the instruction executor.
`timescale 1ns/1ns
`default_nettype none

module teie_exec_asserts (
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        instr_valid_in,
	input wire logic [31:0] instr_word_in,
	input wire logic        cop_access_in,
	input wire logic        multithread_present_in,
	input wire logic        master_flag_in,
	input wire logic [1:0]  vpe_inhibit_in,
	input wire logic        reg_wr_in,
	input wire logic        instr_claimed_out,
	input wire logic        exc_cop_unusable_out,
	input wire logic [1:0]  exc_cop_unit_out,
	input wire logic        exc_reserved_out,
	input wire logic        gpr_wr_out,
	input wire logic [4:0]  gpr_idx_out,
	input wire logic [31:0] gpr_data_out,
	input wire logic [4:0]  cop_rd_out,
	input wire logic [2:0]  cop_sel_out,
	input wire logic        threads_on_out,
	input wire logic        vpes_enabled_out,
	input wire logic [1:0]  vpe_run_out
);
	// ****************
	// Decode helpers.
	// ****************
	logic grp_hit;
	logic thr_hit;
	logic pe_hit;
	logic run_ok;

	// A group word is recognised here independently of the design's decoder.
	assign grp_hit = instr_valid_in && instr_word_in[31:26] == teie_pkg::OPC_VALUE
		&& instr_word_in[15:11] == teie_pkg::MID_VALUE && instr_word_in[2:0] == 3'h0
		&& instr_word_in[9:3] == teie_pkg::FN_VALUE && instr_word_in[20:17] == 4'h0;
	assign thr_hit = grp_hit && instr_word_in[16];
	assign pe_hit  = grp_hit && !instr_word_in[16];
	assign run_ok  = grp_hit && cop_access_in && multithread_present_in;

	// ****************
	// Properties.
	// ****************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_claim_outcome:
		assert property (grp_hit |=> instr_claimed_out
			&& $onehot({exc_cop_unusable_out, exc_reserved_out, gpr_wr_out}))
		else $error("claim or outcome wrong");
	a_unusable_first:
		assert property (grp_hit && !cop_access_in |=> exc_cop_unusable_out
			&& exc_cop_unit_out == 2'h0)
		else $error("unusable not raised");
	a_absent_reserved:
		assert property (run_ok == 1'b0 && grp_hit && cop_access_in |=> exc_reserved_out)
		else $error("reserved not raised");
	a_refused_keeps:
		assert property (grp_hit && !run_ok && !reg_wr_in
			|=> $stable(threads_on_out) && $stable(vpes_enabled_out))
		else $error("refused op changed a bit");
	a_thread_write:
		assert property (thr_hit && run_ok |=> cop_rd_out == teie_pkg::PVC_RD
			&& cop_sel_out == teie_pkg::PVC_SEL && threads_on_out == $past(instr_word_in[10]))
		else $error("thread op wrong");
	a_thread_old:
		assert property (thr_hit && run_ok |=> gpr_data_out[15] == $past(threads_on_out))
		else $error("old thread value wrong");
	a_keep_index:
		assert property (run_ok |=> gpr_wr_out && gpr_idx_out == $past(instr_word_in[25:21]))
		else $error("target index wrong");
	a_pe_register:
		assert property (pe_hit && run_ok |=> cop_rd_out == teie_pkg::MPC_RD
			&& cop_sel_out == teie_pkg::MPC_SEL && gpr_data_out[0] == $past(vpes_enabled_out))
		else $error("wide register op wrong");
	a_master_update:
		assert property (pe_hit && run_ok && master_flag_in
			|=> vpes_enabled_out == $past(instr_word_in[10]))
		else $error("enable bit not updated");
	a_no_master_keep:
		assert property (pe_hit && run_ok && !master_flag_in |=> $stable(vpes_enabled_out))
		else $error("enable bit changed without master");
	a_run_follows:
		assert property (vpe_run_out == (vpes_enabled_out ? ~vpe_inhibit_in : 2'b00))
		else $error("run mask wrong");

	c_thread_run: cover property (thr_hit && run_ok);
	c_pe_no_master: cover property (pe_hit && run_ok && !master_flag_in);
	c_cop_block: cover property (grp_hit && !cop_access_in);

endmodule : teie_exec_asserts

bind teie_exec teie_exec_asserts u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
	.instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
	.cop_access_in(cop_access_in), .multithread_present_in(multithread_present_in),
	.master_flag_in(master_flag_in), .vpe_inhibit_in(vpe_inhibit_in), .reg_wr_in(reg_wr_in),
	.instr_claimed_out(instr_claimed_out), .exc_cop_unusable_out(exc_cop_unusable_out),
	.exc_cop_unit_out(exc_cop_unit_out), .exc_reserved_out(exc_reserved_out),
	.gpr_wr_out(gpr_wr_out), .gpr_idx_out(gpr_idx_out), .gpr_data_out(gpr_data_out),
	.cop_rd_out(cop_rd_out), .cop_sel_out(cop_sel_out), .threads_on_out(threads_on_out),
	.vpes_enabled_out(vpes_enabled_out), .vpe_run_out(vpe_run_out));

`default_nettype wire

/* verif/teie_exec_test.sv */
// Self-checking bench for the thread and VIRTUAL_PROCESSOR_ELEMENT enable instruction executor.
`timescale 1ns/1ns
`default_nettype none

`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module teie_exec_test;
	logic        mclk_in, rst_in, instr_valid_in, cop_access_in;
	logic        multithread_present_in, master_flag_in, reg_wr_in, reg_rd_in;
	logic [31:0] instr_word_in, reg_wdata_in, reg_rdata_out, gpr_data_out;
	logic [1:0]  vpe_inhibit_in, exc_cop_unit_out, vpe_run_out;
	logic [7:0]  reg_addr_in;
	logic        instr_claimed_out, exc_cop_unusable_out, exc_reserved_out, gpr_wr_out;
	logic        threads_on_out, vpes_enabled_out, irq_out;
	logic [4:0]  gpr_idx_out, cop_rd_out, stat_m, mask_m;
	logic [2:0]  cop_sel_out;
	logic [31:0] pvc_m, mpc_m, last_m, rnd;
	int          errors, total_checks;

	teie_exec uut (.mclk_in(mclk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
		.instr_word_in(instr_word_in), .cop_access_in(cop_access_in),
		.multithread_present_in(multithread_present_in), .master_flag_in(master_flag_in),
		.vpe_inhibit_in(vpe_inhibit_in), .instr_claimed_out(instr_claimed_out),
		.exc_cop_unusable_out(exc_cop_unusable_out), .exc_cop_unit_out(exc_cop_unit_out),
		.exc_reserved_out(exc_reserved_out), .gpr_wr_out(gpr_wr_out),
		.gpr_idx_out(gpr_idx_out), .gpr_data_out(gpr_data_out), .cop_rd_out(cop_rd_out),
		.cop_sel_out(cop_sel_out), .threads_on_out(threads_on_out),
		.vpes_enabled_out(vpes_enabled_out), .vpe_run_out(vpe_run_out),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

	// Free-running 125 MHz clock.
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	// ****************
	// Bus and model helpers.
	// ****************
	// Expected register contents, worked out from the bench model.
	function automatic logic [31:0] exp_reg(input logic [7:0] a);
		case (a)
			teie_pkg::OFS_PER_VPE_CTRL: return pvc_m;
			teie_pkg::OFS_MULTI_CTRL:   return mpc_m;
			teie_pkg::OFS_IRQ_STATUS:   return {27'h0, stat_m};
			teie_pkg::OFS_IRQ_MASK:     return {27'h0, mask_m};
			teie_pkg::OFS_LAST_RESULT:  return last_m;
			default:                    return 32'h0000_0000;
		endcase
	endfunction : exp_reg

	// One-cycle write strobe, then the model follows the write.
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		case (a)
			teie_pkg::OFS_PER_VPE_CTRL: pvc_m = d;
			teie_pkg::OFS_MULTI_CTRL:   mpc_m = d;
			teie_pkg::OFS_IRQ_STATUS:   stat_m = stat_m & ~d[4:0];
			teie_pkg::OFS_IRQ_MASK:     mask_m = d[4:0];
			default:                    ;
		endcase
		#1;
	endtask : reg_write

	// Reads every mapped offset plus an unmapped one; data stand one cycle after the strobe.
	// Reads start only after the last update edge, as a barrier would ensure.
	task automatic check_regs();
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk_in);
			reg_rd_in <= 1'b1;
			reg_addr_in <= 8'(i * 4);
			@(posedge mclk_in);
			reg_rd_in <= 1'b0;
			#1;
			`CHECK(reg_rdata_out, exp_reg(8'(i * 4)))
		end
		`CHECK(irq_out, |(stat_m & mask_m))
	endtask : check_regs

	// Issues one word of the group (or a corrupted one) and checks every result.
	task automatic run_instr(input logic thr, input logic setclr, input logic [4:0] tgt,
			input logic [2:0] flg, input logic bad);
		logic [31:0] word;
		logic [31:0] old;
		logic        hit;
		logic        run;
		word = {teie_pkg::OPC_VALUE, tgt, thr ? teie_pkg::SEL_THREAD : teie_pkg::SEL_VPE,
			teie_pkg::MID_VALUE, setclr, teie_pkg::FN_VALUE, teie_pkg::LOW_VALUE};
		word[3] = word[3] ^ bad;
		@(posedge mclk_in);
		instr_valid_in <= 1'b1;
		instr_word_in <= word;
		cop_access_in <= flg[0];
		multithread_present_in <= flg[1];
		master_flag_in <= flg[2];
		vpe_inhibit_in <= 2'($urandom());
		@(posedge mclk_in);
		instr_valid_in <= 1'b0;
		// Enable levels are trusted only a cycle after issue, never at once.
		#1;
		hit = !bad;
		run = hit && flg[0] && flg[1];
		old = thr ? pvc_m : mpc_m;
		`CHECK(instr_claimed_out, hit)
		`CHECK(exc_cop_unusable_out, hit && !flg[0])
		`CHECK(exc_cop_unit_out, 2'h0)
		`CHECK(exc_reserved_out, hit && flg[0] && !flg[1])
		`CHECK(gpr_wr_out, run)
		if (hit && !flg[0]) stat_m[teie_pkg::EVT_COP_UNUSE] = 1'b1;
		else if (hit && !flg[1]) stat_m[teie_pkg::EVT_RESERVED] = 1'b1;
		if (run) begin
			`CHECK(gpr_idx_out, tgt)
			`CHECK(gpr_data_out, old)
			`CHECK({cop_rd_out, cop_sel_out}, thr ? 8'h09 : 8'h01)
			last_m = old;
			stat_m[thr ? teie_pkg::EVT_THREAD_OP : teie_pkg::EVT_VPE_OP] = 1'b1;
			if (thr) pvc_m[teie_pkg::THREADS_ON_POS] = setclr;
			else if (flg[2]) mpc_m[teie_pkg::VPES_ENABLED_POS] = setclr;
			else stat_m[teie_pkg::EVT_NOT_MASTR] = 1'b1;
		end
		`CHECK(threads_on_out, pvc_m[15])
		`CHECK(vpes_enabled_out, mpc_m[0])
		`CHECK(vpe_run_out, mpc_m[0] ? ~vpe_inhibit_in : 2'b00)
		`CHECK(irq_out, |(stat_m & mask_m))
	endtask : run_instr

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge mclk_in);
		errors++;
		summarize();
	end

	// ****************
	// Main sequence.
	// ****************
	initial begin
		{instr_valid_in, cop_access_in, multithread_present_in, master_flag_in} = 4'h0;
		{reg_wr_in, reg_rd_in, vpe_inhibit_in, reg_addr_in} = 12'h000;
		instr_word_in = 32'h0000_0000;
		reg_wdata_in = 32'h0000_0000;
		{pvc_m, mpc_m, last_m} = {teie_pkg::PVC_RESET, teie_pkg::MPC_RESET, 32'h0000_0000};
		{stat_m, mask_m} = 10'h000;
		errors = 0;
		total_checks = 0;
		rnd = $urandom(52);
		rst_in = 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		check_regs();
		reg_write(teie_pkg::OFS_PER_VPE_CTRL, $urandom());
		reg_write(teie_pkg::OFS_MULTI_CTRL, $urandom());
		reg_write(teie_pkg::OFS_IRQ_MASK, 32'h0000_001F);
		check_regs();
		// Every kind and set-clear value under every permission mix, target 0 and 31.
		for (int k = 0; k < 32; k++) begin
			run_instr(k[0], k[1], (k % 3 == 0) ? 5'h00 : 5'h1F, 3'(k >> 2), 1'b0);
		end
		check_regs();
		// Masking and write-one-to-clear of the sticky events.
		reg_write(teie_pkg::OFS_IRQ_MASK, 32'h0000_0004);
		reg_write(teie_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
		check_regs();
		run_instr(1'b1, 1'b1, 5'h03, 3'h6, 1'b0);
		run_instr(1'b0, 1'b0, 5'h04, 3'h6, 1'b0);
		reg_write(teie_pkg::OFS_IRQ_STATUS, 32'hFFFF_FFFF);
		check_regs();
		// Random traffic with corrupted words and register writes mixed in.
		for (int k = 0; k < 60; k++) begin
			rnd = $urandom();
			if (rnd[20:18] == 3'h0) reg_write({5'h00, rnd[17:16] == 2'h0, 2'h0}, $urandom());
			run_instr(rnd[0], rnd[1], rnd[6:2], rnd[9:7], rnd[13:10] == 4'h0);
		end
		check_regs();
		// Corners: a port write in the cycle of an executing thread op; the op and its event win.
		for (int k = 0; k < 2; k++) begin
			fork
				run_instr(1'b1, 1'b0, 5'h02, 3'h7, 1'b0);
				begin
					@(posedge mclk_in);
					reg_wr_in <= 1'b1;
					reg_addr_in <= k[0] ? teie_pkg::OFS_IRQ_STATUS : teie_pkg::OFS_PER_VPE_CTRL;
					reg_wdata_in <= 32'hFFFF_FFFF;
					@(posedge mclk_in);
					reg_wr_in <= 1'b0;
					if (k[0]) stat_m = 5'h00;
				end
			join
		end
		check_regs();
		summarize();
	end
endmodule : teie_exec_test

`default_nettype wire
